/* File: hw/dmic_params.svh */
// constants for the direct-mapped instruction cache
// assumes 32-bit byte addresses and 32-bit instruction words
`ifndef DMIC_PARAMS_SVH
`define DMIC_PARAMS_SVH
`define DMIC_LINES        256
`define DMIC_WORDS        1024
`define DMIC_TAG_W        20
`define DMIC_TAG_HI       31
`define DMIC_TAG_LO       12
`define DMIC_IDX_HI       11
`define DMIC_IDX_LO       4
`define DMIC_WIDX_LO      2
`define DMIC_WSEL_HI      3
`define DMIC_CTL_ENABLE   31
`define DMIC_CTL_INV_ALL  24
`define DMIC_CTL_INV_LOCK 28
`define DMIC_CTL_RESET    32'h0000_0000
`define DMIC_IDX_LAST     8'hFF
`endif

/* File: hw/dmic_pkg.sv */
// types for the direct-mapped instruction cache
// assumes nothing beyond the params header
package dmic_pkg;
   typedef enum logic [1:0] {
      DMIC_IDLE,
      DMIC_CLEAR,
      DMIC_FILL
   } dmic_state_t;
endpackage : dmic_pkg

/* File: hw/dmic_cache.sv */
// direct-mapped 4 KB instruction cache with a 16-byte line-fill buffer
// assumes the core holds a fetch until o_fetch_ack, the SRAM decodes its own
// range, and the memory side answers one longword per accepted request
// tag and data arrays have no reset: software runs the whole invalidate
// before it sets the enable bit, or stale lines could hit
`include "dmic_params.svh"
`timescale 1ns/1ns
`default_nettype none

module dmic_cache (
   input  wire logic        i_sys_clk,     // core clock, 125 MHz
   input  wire logic        i_rst,         // async reset, active high
   input  wire logic        i_fetch_req,   // instruction fetch (core or debug)
   input  wire logic [31:0] i_fetch_addr,  // fetch byte address
   input  wire logic        i_sram_hit,    // fetch lies in the SRAM range
   output logic             o_fetch_ack,   // fetch answered this cycle
   output logic [31:0]      o_fetch_data,  // fetched instruction word
   input  wire logic        i_ctl_wr,      // write strobe for control word
   input  wire logic [31:0] i_ctl_data,    // new control word value
   input  wire logic        i_line_inv,    // line invalidate instruction
   input  wire logic [31:0] i_line_addr,   // its source address
   output logic             o_ctl_enable,  // cache enabled
   output logic             o_inv_busy,    // whole invalidate running
   output logic             o_mem_req,     // external longword request
   output logic [31:0]      o_mem_addr,    // external longword address
   input  wire logic        i_mem_ack,     // external request accepted
   input  wire logic        i_mem_valid,   // external data returned
   input  wire logic [31:0] i_mem_data     // external data
);

   // storage
   logic [`DMIC_TAG_W-1:0] tag_mem  [`DMIC_LINES];
   logic                   tag_vld  [`DMIC_LINES];
   logic [31:0]            data_mem [`DMIC_WORDS];

   logic [31:0]            ctl;
   dmic_pkg::dmic_state_t  state;
   logic [7:0]             clr_idx;
   logic [31:4]            fb_addr;
   logic [31:0]            fb_data [4];
   logic [3:0]             fb_vld;
   logic                   fb_pend;       // buffer holds a line still to commit
   logic [1:0]             req_cnt;       // longwords requested so far
   logic [1:0]             rsp_cnt;       // longwords returned so far
   logic                   req_done;
   logic                   core_wait;     // core stalled on the critical word
   logic [1:0]             crit;          // critical longword of the running fill

   function automatic logic [7:0] line_idx(input logic [31:0] a);
      line_idx = a[`DMIC_IDX_HI:`DMIC_IDX_LO];
   endfunction : line_idx

   function automatic logic [1:0] word_sel(input logic [31:0] a);
      word_sel = a[`DMIC_WSEL_HI:`DMIC_WIDX_LO];
   endfunction : word_sel

   // hit decode
   logic [7:0]  f_idx;
   logic [9:0]  f_widx;
   logic [1:0]  f_wsel;
   logic        arr_hit;
   logic        fb_line;
   logic        fb_hit;
   logic        miss;
   logic        enabled;

   assign enabled = ctl[`DMIC_CTL_ENABLE];
   assign f_idx   = line_idx(i_fetch_addr);
   assign f_widx  = i_fetch_addr[`DMIC_IDX_HI:`DMIC_WIDX_LO];
   assign f_wsel  = word_sel(i_fetch_addr);
   assign arr_hit = tag_vld[f_idx] &&
                    (tag_mem[f_idx] == i_fetch_addr[`DMIC_TAG_HI:`DMIC_TAG_LO]);
   // buffer line match ignores the longword valid bits
   assign fb_line = (fb_addr == i_fetch_addr[`DMIC_TAG_HI:`DMIC_IDX_LO]);
   assign fb_hit  = fb_line && fb_vld[f_wsel];
   // a fetch is serviceable when enabled, outside the SRAM range, not stalled on a miss, and the clear sequence is not running
   logic        fetch_ok;
   assign fetch_ok = i_fetch_req && !i_sram_hit && enabled && (state != dmic_pkg::DMIC_CLEAR)
                     && !core_wait;
   assign miss     = fetch_ok && !arr_hit && !fb_hit && !fb_line
                     && (state == dmic_pkg::DMIC_IDLE);

   // decodes shared by the tag, data and buffer logic
   logic        commit;
   logic        inv_line;
   logic [1:0]  fill_wsel;    // buffer slot of the longword now returning
   logic [7:0]  fb_idx;       // array line that the buffer belongs to

   // only a complete line is copied, and only when the next miss frees the buffer
   assign commit    = miss && fb_pend && (&fb_vld);
   // the lock bit keeps single-line invalidates out
   assign inv_line  = i_line_inv && !ctl[`DMIC_CTL_INV_LOCK];
   // data returns critical word first, so the slot is offset from crit
   assign fill_wsel = crit + rsp_cnt;
   assign fb_idx    = fb_addr[`DMIC_IDX_HI:`DMIC_IDX_LO];

   // control word
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ctl <= `DMIC_CTL_RESET;
      end else if (i_ctl_wr) begin
         ctl <= i_ctl_data;
      end else if (state == dmic_pkg::DMIC_CLEAR && clr_idx == `DMIC_IDX_LAST) begin
         ctl[`DMIC_CTL_INV_ALL] <= 1'b0;
      end
   end

   // sequencer: clear walk and line fill
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state   <= dmic_pkg::DMIC_IDLE;
         clr_idx <= 8'h00;
      end else begin
         case (state)
            // a requested whole invalidate outranks a new miss
            dmic_pkg::DMIC_IDLE: begin
               if (ctl[`DMIC_CTL_INV_ALL]) begin
                  state   <= dmic_pkg::DMIC_CLEAR;
                  clr_idx <= 8'h00;
               end else if (miss) begin
                  state <= dmic_pkg::DMIC_FILL;
               end
            end
            // one tag location per cycle
            dmic_pkg::DMIC_CLEAR: begin
               clr_idx <= clr_idx + 8'h01;
               if (clr_idx == `DMIC_IDX_LAST) begin
                  state <= dmic_pkg::DMIC_IDLE;
               end
            end
            // stays until the fourth longword has returned
            dmic_pkg::DMIC_FILL: begin
               if (i_mem_valid && rsp_cnt == 2'h3) begin
                  state <= dmic_pkg::DMIC_IDLE;
               end
            end
            default: state <= dmic_pkg::DMIC_IDLE;
         endcase
      end
   end

   // tag array: clear walk, line invalidate, commit; no reset on contents
   always_ff @(posedge i_sys_clk) begin
      if (state == dmic_pkg::DMIC_CLEAR) begin
         tag_vld[clr_idx] <= 1'b0;
      end else begin
         if (commit) begin
            tag_mem[fb_idx] <= fb_addr[`DMIC_TAG_HI:`DMIC_TAG_LO];
            tag_vld[fb_idx] <= 1'b1;
         end
         // both in one cycle: a lost commit would leave new data under an old tag
         // an invalidate of the same line comes last and wins
         if (inv_line) begin
            tag_vld[line_idx(i_line_addr)] <= 1'b0;
         end
      end
   end

   // data array: whole line written in one commit
   always_ff @(posedge i_sys_clk) begin
      if (commit) begin
         for (int w = 0; w < 4; w++) begin
            data_mem[{fb_idx, 2'(w)}] <= fb_data[w];
         end
      end
   end

   // fill buffer
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         fb_addr <= 28'h0000000;
         fb_vld  <= 4'h0;
         fb_pend <= 1'b0;
         for (int w = 0; w < 4; w++) begin
            fb_data[w] <= 32'h0000_0000;
         end
      end else if (miss) begin
         fb_addr <= i_fetch_addr[31:4];
         fb_vld  <= 4'h0;
         fb_pend <= 1'b1;
      end else begin
         // a running fill is never dropped, so set and clear cannot meet
         if (inv_line && state != dmic_pkg::DMIC_FILL
             && line_idx(i_line_addr) == fb_idx) begin
            fb_vld  <= 4'h0;
            fb_pend <= 1'b0;
         end else if (state == dmic_pkg::DMIC_FILL && i_mem_valid) begin
            fb_data[fill_wsel] <= i_mem_data;
            fb_vld[fill_wsel]  <= 1'b1;
         end
         if (state == dmic_pkg::DMIC_CLEAR) begin
            fb_vld  <= 4'h0;
            fb_pend <= 1'b0;
         end
      end
   end

   // burst request side, critical word first, wrapping
   // the address advances only on an accepted request
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         crit     <= 2'h0;
         req_cnt  <= 2'h0;
         req_done <= 1'b0;
         rsp_cnt  <= 2'h0;
         o_mem_req  <= 1'b0;
         o_mem_addr <= 32'h0000_0000;
      end else if (miss) begin
         crit       <= f_wsel;
         req_cnt    <= 2'h0;
         req_done   <= 1'b0;
         rsp_cnt    <= 2'h0;
         o_mem_req  <= 1'b1;
         o_mem_addr <= {i_fetch_addr[31:2], 2'h0};
      end else if (state == dmic_pkg::DMIC_FILL) begin
         if (i_mem_valid) begin
            rsp_cnt <= rsp_cnt + 2'h1;
         end
         if (o_mem_req && i_mem_ack) begin
            if (req_cnt == 2'h3) begin
               o_mem_req <= 1'b0;
               req_done  <= 1'b1;
            end else begin
               req_cnt    <= req_cnt + 2'h1;
               o_mem_addr <= {fb_addr, crit + req_cnt + 2'h1, 2'h0};
            end
         end
      end
   end

   // core answer
   // an ack blocks a second ack next cycle: the core drops its
   // request only after it has seen the first
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_fetch_ack  <= 1'b0;
         o_fetch_data <= 32'h0000_0000;
         core_wait    <= 1'b0;
      end else begin
         o_fetch_ack <= 1'b0;
         if (miss) begin
            core_wait <= 1'b1;
         end else if (core_wait && state == dmic_pkg::DMIC_FILL && i_mem_valid
                      && rsp_cnt == 2'h0) begin
            core_wait    <= 1'b0;
            o_fetch_ack  <= 1'b1;
            o_fetch_data <= i_mem_data;
         end else if (fetch_ok && !o_fetch_ack && fb_hit) begin
            o_fetch_ack  <= 1'b1;
            o_fetch_data <= fb_data[f_wsel];
         end else if (fetch_ok && !o_fetch_ack && arr_hit && !fb_line) begin
            o_fetch_ack  <= 1'b1;
            o_fetch_data <= data_mem[f_widx];
         end
         if (core_wait && state == dmic_pkg::DMIC_CLEAR) begin
            core_wait <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ctl_enable <= 1'b0;
      end else begin
         o_ctl_enable <= enabled;
      end
   end

   // busy flag trails the walk by one cycle, like every registered output
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_inv_busy <= 1'b0;
      end else begin
         o_inv_busy <= (state == dmic_pkg::DMIC_CLEAR);
      end
   end

endmodule : dmic_cache
`default_nettype wire

/* File: tb/dmic_cache_properties.sv */
// port assertions for the instruction cache
// assumes one clock and a bind onto dmic_cache
`timescale 1ns/1ns
`default_nettype none
module dmic_cache_chk (
   input wire logic        i_sys_clk,    // clock
   input wire logic        i_rst,        // reset
   input wire logic        i_fetch_req,  // fetch request
   input wire logic        i_sram_hit,   // sram range
   input wire logic        o_fetch_ack,  // fetch answered
   input wire logic        o_ctl_enable, // cache on
   input wire logic        o_inv_busy,   // clear walk
   input wire logic        o_mem_req,    // memory request
   input wire logic [31:0] o_mem_addr,   // memory address
   input wire logic        i_mem_ack     // memory accept
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   logic [8:0]  busy_cnt;
   logic [1:0]  beat;
   logic [31:0] last_addr;
   sequence s_held;
      o_mem_req && !i_mem_ack;
   endsequence
   always_ff @(posedge i_sys_clk or posedge i_rst)
      if (i_rst) busy_cnt <= 9'h000;
      else busy_cnt <= o_inv_busy ? busy_cnt + 9'h001 : 9'h000;
   always_ff @(posedge i_sys_clk or posedge i_rst)
      if (i_rst) beat <= 2'h0;
      else if (o_mem_req && i_mem_ack) beat <= beat + 2'h1;
   always_ff @(posedge i_sys_clk)
      if (o_mem_req && i_mem_ack) last_addr <= o_mem_addr;
   chk_walk_len: assert property ($fell(o_inv_busy) |-> busy_cnt == 9'h100)
      else $error("clear walk length wrong");
   chk_walk_quiet: assert property (o_inv_busy |-> !o_fetch_ack)
      else $error("fetch answered during clear walk");
   chk_off_quiet: assert property (!o_ctl_enable |-> !o_fetch_ack)
      else $error("fetch answered while disabled");
   chk_sram_quiet: assert property (i_fetch_req && i_sram_hit |=> !o_fetch_ack)
      else $error("sram fetch answered by cache");
   chk_ack_gap: assert property (o_fetch_ack |=> !o_fetch_ack)
      else $error("fetch ack longer than one cycle");
   chk_ack_cause: assert property (o_fetch_ack |-> $past(i_fetch_req))
      else $error("fetch ack without request");
   chk_mem_hold: assert property (s_held |=> o_mem_req && $stable(o_mem_addr))
      else $error("memory request dropped or moved");
   chk_wrap_order: assert property (o_mem_req && beat != 2'h0 |->
      o_mem_addr == {last_addr[31:4], last_addr[3:2] + 2'h1, 2'h0})
      else $error("burst word order wrong");
endmodule : dmic_cache_chk
bind dmic_cache dmic_cache_chk chk_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
   .i_fetch_req(i_fetch_req), .i_sram_hit(i_sram_hit), .o_fetch_ack(o_fetch_ack),
   .o_ctl_enable(o_ctl_enable), .o_inv_busy(o_inv_busy), .o_mem_req(o_mem_req),
   .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack));
`default_nettype wire

/* File: tb/dmic_mem_model.sv */
// external memory seen by the cache's line fills
// assumes requests held until accepted; data returns in request order
`timescale 1ns/1ns
`default_nettype none
module dmic_mem_model (
   input  wire logic        i_sys_clk, // clock
   input  wire logic        i_rst,     // reset
   input  wire logic        i_slow,    // accept only every fourth cycle
   input  wire logic        i_req,     // longword request
   input  wire logic [31:0] i_addr,    // longword address
   output logic             o_ack,     // request accepted
   output logic             o_valid,   // data returned
   output logic [31:0]      o_data     // returned word
);
   logic [1:0] stall;
   always_ff @(posedge i_sys_clk or posedge i_rst)
      if (i_rst) stall <= 2'h0;
      else stall <= stall + 2'h1;
   always_ff @(posedge i_sys_clk or posedge i_rst)
      if (i_rst) o_ack <= 1'b0;
      else o_ack <= i_req && !o_ack && (!i_slow || stall == 2'h3);
   // idle data bus inverts its previous value every cycle
   always_ff @(posedge i_sys_clk or posedge i_rst)
      if (i_rst) o_valid <= 1'b0;
      else o_valid <= i_req && o_ack;
   always_ff @(posedge i_sys_clk)
      o_data <= (i_req && o_ack) ? i_addr ^ 32'h5A5A_C3C3 : ~o_data;
endmodule : dmic_mem_model
`default_nettype wire

/* File: tb/test_direct_mapped_instruction_cache.sv */
// self-checking bench for the instruction cache
// assumes the cache, its checker and the memory model are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_direct_mapped_instruction_cache;
   logic        i_sys_clk, i_rst, i_fetch_req, i_sram_hit, i_ctl_wr, i_line_inv, i_slow;
   logic        o_fetch_ack, o_ctl_enable, o_inv_busy, o_mem_req, i_mem_ack, i_mem_valid;
   logic [31:0] i_fetch_addr, i_ctl_data, i_line_addr, o_fetch_data, o_mem_addr, i_mem_data;
   logic [31:0] acc[$];
   logic [31:0] d;
   int          num_errors, compares, nval, n, base, k;
   localparam logic [31:0] A = 32'h0001_2348, B = 32'h0003_4560, C = 32'h0001_3348;
   dmic_cache dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_fetch_req(i_fetch_req),
      .i_fetch_addr(i_fetch_addr), .i_sram_hit(i_sram_hit), .o_fetch_ack(o_fetch_ack),
      .o_fetch_data(o_fetch_data), .i_ctl_wr(i_ctl_wr), .i_ctl_data(i_ctl_data),
      .i_line_inv(i_line_inv), .i_line_addr(i_line_addr), .o_ctl_enable(o_ctl_enable),
      .o_inv_busy(o_inv_busy), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
      .i_mem_ack(i_mem_ack), .i_mem_valid(i_mem_valid), .i_mem_data(i_mem_data));
   dmic_mem_model mem_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_slow(i_slow),
      .i_req(o_mem_req), .i_addr(o_mem_addr), .o_ack(i_mem_ack), .o_valid(i_mem_valid),
      .o_data(i_mem_data));
   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      if (o_mem_req === 1'b1 && i_mem_ack === 1'b1) acc.push_back(o_mem_addr);
      if (i_mem_valid === 1'b1) nval++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict;
      if (num_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   task automatic pulse(input logic [31:0] v, input bit line);
      @(negedge i_sys_clk);
      {i_ctl_wr, i_line_inv} = {!line, line};
      i_ctl_data = v;
      i_line_addr = v;
      @(negedge i_sys_clk);
      {i_ctl_wr, i_line_inv} = 2'b00;
   endtask : pulse
   task automatic fetch(input logic [31:0] a, input int lim);
      @(negedge i_sys_clk);
      i_fetch_req = 1'b1;
      i_fetch_addr = a;
      for (n = 0; n < lim && o_fetch_ack !== 1'b1; n++) @(negedge i_sys_clk);
      d = o_fetch_data;
      i_fetch_req = 1'b0;
   endtask : fetch
   task automatic miss_start(input logic [31:0] a);
      base = acc.size();
      fetch(a, 400);
      check(d, a ^ 32'h5A5A_C3C3);
   endtask : miss_start
   task automatic miss_end(input logic [31:0] a);
      for (k = 0; k < 400 && nval < base + 4; k++) @(negedge i_sys_clk);
      check(acc.size(), base + 4);
      for (k = 0; k < 4; k++) check(acc[base + k], {a[31:4], a[3:2] + 2'(k), 2'h0});
   endtask : miss_end
   task automatic t_reset;
      check(o_ctl_enable, 0);
      fetch(A, 20);
      check(n, 20);
      check(acc.size(), 0);
   endtask : t_reset
   task automatic t_clear_and_buffer;
      pulse(32'h8100_0000, 1'b0);
      repeat (2) @(negedge i_sys_clk);
      check(o_inv_busy, 1);
      miss_start(A);
      check(n > 256, 1);
      miss_end(A);
      for (k = 0; k < 4; k++) begin
         fetch({A[31:4], 2'(k), 2'h0}, 10);
         check(n, 1);
         check(d, {A[31:4], 2'(k), 2'h0} ^ 32'h5A5A_C3C3);
      end
   endtask : t_clear_and_buffer
   task automatic t_commit_nonblocking;
      i_slow = 1'b1;
      miss_start(B);
      fetch(A, 10);
      check(n, 1);
      check(nval < base + 4, 1);
      check(d, A ^ 32'h5A5A_C3C3);
      miss_end(B);
      i_slow = 1'b0;
      miss_start(C);
      miss_end(C);
      fetch(B, 10);
      check(n, 1);
   endtask : t_commit_nonblocking
   task automatic t_sram_and_invalidate;
      i_sram_hit = 1'b1;
      fetch(32'h0020_0010, 10);
      check(n, 10);
      i_sram_hit = 1'b0;
      check(acc.size(), 12);
      pulse(B, 1'b1);
      miss_start(B);
      miss_end(B);
      pulse(32'h9000_0000, 1'b0);
      pulse(C, 1'b1);
      fetch(C, 10);
      check(n, 1);
      check(d, C ^ 32'h5A5A_C3C3);
   endtask : t_sram_and_invalidate
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      num_errors++;
      print_verdict;
   end
   initial begin
      {i_rst, i_fetch_req, i_sram_hit, i_ctl_wr, i_line_inv, i_slow} = 6'b100000;
      {i_fetch_addr, i_ctl_data, i_line_addr} = '0;
      repeat (2) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      i_rst = 1'b0;
      t_reset;
      t_clear_and_buffer;
      t_commit_nonblocking;
      t_sram_and_invalidate;
      print_verdict;
   end
endmodule : test_direct_mapped_instruction_cache
`default_nettype wire
